// ==== design/charge_reg_pkg.sv ====
// constants and carriers for the charge-current register block
// assumes a byte-wide register port driven by an upstream serial slave
package charge_reg_pkg;
   localparam logic [7:0] ADDR_DEVICE_IDENTIFICATION = 8'h03;
   localparam logic [7:0] ADDR_CHARGE_TERMINATION_CURRENT = 8'h04;
   localparam logic [7:0] CHARGE_TERMINATION_RESET = 8'h89;
   localparam int RESET_BIT = 7;
   localparam int CHRG_MSB = 6;
   localparam int CHRG_LSB = 4;
   localparam int TERM_MSB = 2;
   localparam int TERM_LSB = 0;
   localparam int SPARE_BIT = 3;
   localparam logic [2:0] CHRG_RESET = 3'h0;
   localparam logic [2:0] TERM_RESET = 3'h1;
   // revision code value is arbitrary
   localparam logic [2:0] SILICON_REV_FIELD = 3'h2;
   // upper identification bits are arbitrary
   localparam logic [4:0] ID_UPPER = 5'h00;
   localparam logic [2:0] FAULT_NORMAL = 3'h0;
   localparam logic [2:0] FAULT_TIMER = 3'h6;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int SAFETY_TIME_MS = 1800000;
   localparam int CLK_MHZ = 50;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {ST_READY, ST_CHARGING, ST_DONE, ST_FAULT} charge_state_t;
endpackage : charge_reg_pkg

// ==== design/safety_timer.sv ====
// safety timer that counts while run_i is high and holds at the limit, with restart and expiry flag
// assumes ref clock domain; limit supplied by parent
`timescale 1ns/10ps
module safety_timer #(
   parameter longint unsigned LIMIT = 64'd1000
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic run_i,
   input wire logic restart_i,
   output logic expired_o
);
   logic [63:0] count_q;
   logic [63:0] count_d;
   logic expired_q;
   logic expired_d;

   always_comb begin
      count_d = count_q;
      expired_d = expired_q;
      if (restart_i) begin
         count_d = 64'h0;
         expired_d = 1'b0;
      end else if (run_i && !expired_q) begin
         if (count_q >= LIMIT - 64'd1) begin
            expired_d = 1'b1;
         end else begin
            count_d = count_q + 64'd1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_q <= 64'h0;
         expired_q <= 1'b0;
      end else if (clk_en_i) begin
         count_q <= count_d;
         expired_q <= expired_d;
      end
   end

   assign expired_o = expired_q;
endmodule : safety_timer

// ==== design/charge_current_register_block.sv ====
// charge/termination current register, identification register, charge cycle
// assumes a serial slave presents byte requests synchronous to ref_clk_i
`timescale 1ns/10ps
module charge_current_register_block #(
   parameter longint unsigned SAFETY_CYCLES =
      64'(charge_reg_pkg::SAFETY_TIME_MS) * 64'd1000 * 64'(charge_reg_pkg::CLK_MHZ)
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire charge_reg_pkg::reg_req_t req_i,
   input wire logic termination_allow_i,
   input wire logic charge_enable_i,
   input wire logic below_refresh_i,
   input wire logic low_current_i,
   output logic [7:0] rdata_o,
   output logic [2:0] fast_charge_sense_threshold_o,
   output logic [2:0] termination_sense_threshold_o,
   output logic charger_reset_o,
   output logic charging_o,
   output logic [2:0] fault_o,
   output charge_reg_pkg::charge_state_t state_o
);
   logic [2:0] chrg_q, chrg_d, term_q, term_d;
   logic spare_q, spare_d;
   logic rst_pulse_q, rst_pulse_d;
   logic [7:0] rdata_q, rdata_d;
   logic [2:0] fault_q, fault_d;
   charge_reg_pkg::charge_state_t state_q, state_d;
   logic charging_q, charging_d;
   logic timer_expired;
   logic timer_restart;
   logic wr_cur;

   assign wr_cur = req_i.wr && (req_i.addr == charge_reg_pkg::ADDR_CHARGE_TERMINATION_CURRENT);

   always_comb begin
      chrg_d = chrg_q;
      term_d = term_q;
      spare_d = spare_q;
      rst_pulse_d = 1'b0;
      rdata_d = rdata_q;
      if (wr_cur) begin
         rst_pulse_d = req_i.wdata[charge_reg_pkg::RESET_BIT];
         chrg_d = req_i.wdata[charge_reg_pkg::CHRG_MSB:charge_reg_pkg::CHRG_LSB];
         term_d = req_i.wdata[charge_reg_pkg::TERM_MSB:charge_reg_pkg::TERM_LSB];
         // unused bit stored
         spare_d = req_i.wdata[charge_reg_pkg::SPARE_BIT];
      end
      if (rst_pulse_q) begin
         chrg_d = charge_reg_pkg::CHRG_RESET;
         term_d = charge_reg_pkg::TERM_RESET;
         spare_d = charge_reg_pkg::CHARGE_TERMINATION_RESET[charge_reg_pkg::SPARE_BIT];
      end
      if (req_i.rd) begin
         if (req_i.addr == charge_reg_pkg::ADDR_CHARGE_TERMINATION_CURRENT) begin
            rdata_d = {1'b1, chrg_q, spare_q, term_q};
         end else if (req_i.addr == charge_reg_pkg::ADDR_DEVICE_IDENTIFICATION) begin
            rdata_d = {charge_reg_pkg::ID_UPPER, charge_reg_pkg::SILICON_REV_FIELD};
         end else begin
            rdata_d = charge_reg_pkg::READ_UNMAPPED;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chrg_q <= charge_reg_pkg::CHRG_RESET;
         term_q <= charge_reg_pkg::TERM_RESET;
         spare_q <= charge_reg_pkg::CHARGE_TERMINATION_RESET[charge_reg_pkg::SPARE_BIT];
         rst_pulse_q <= 1'b0;
         rdata_q <= charge_reg_pkg::READ_UNMAPPED;
      end else if (clk_en_i) begin
         chrg_q <= chrg_d;
         term_q <= term_d;
         spare_q <= spare_d;
         rst_pulse_q <= rst_pulse_d;
         rdata_q <= rdata_d;
      end
   end

   // charge cycle sequencing
   always_comb begin
      state_d = state_q;
      fault_d = fault_q;
      case (state_q)
         charge_reg_pkg::ST_READY: begin
            if (charge_enable_i) begin
               state_d = charge_reg_pkg::ST_CHARGING;
               fault_d = charge_reg_pkg::FAULT_NORMAL;
            end
         end
         charge_reg_pkg::ST_CHARGING: begin
            if (timer_expired) begin
               state_d = charge_reg_pkg::ST_FAULT;
               fault_d = charge_reg_pkg::FAULT_TIMER;
            end else if (!charge_enable_i) begin
               state_d = charge_reg_pkg::ST_READY;
            end else if (low_current_i && termination_allow_i) begin
               state_d = charge_reg_pkg::ST_DONE;
            end
         end
         charge_reg_pkg::ST_DONE: begin
            if (!charge_enable_i) begin
               state_d = charge_reg_pkg::ST_READY;
            end else if (below_refresh_i) begin
               state_d = charge_reg_pkg::ST_CHARGING;
            end
         end
         default: begin
            if (!charge_enable_i) begin
               state_d = charge_reg_pkg::ST_READY;
            end
         end
      endcase
      if (rst_pulse_q) begin
         state_d = charge_reg_pkg::ST_READY;
         fault_d = charge_reg_pkg::FAULT_NORMAL;
      end
      charging_d = (state_d == charge_reg_pkg::ST_CHARGING);
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= charge_reg_pkg::ST_READY;
         fault_q <= charge_reg_pkg::FAULT_NORMAL;
         charging_q <= 1'b0;
      end else if (clk_en_i) begin
         state_q <= state_d;
         fault_q <= fault_d;
         charging_q <= charging_d;
      end
   end

   assign timer_restart = (state_q != charge_reg_pkg::ST_CHARGING);

   safety_timer #(
      .LIMIT(SAFETY_CYCLES)
   ) u_safety_timer (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .run_i(state_q == charge_reg_pkg::ST_CHARGING),
      .restart_i(timer_restart),
      .expired_o(timer_expired)
   );

   assign rdata_o = rdata_q;
   assign fast_charge_sense_threshold_o = chrg_q;
   assign termination_sense_threshold_o = term_q;
   assign charger_reset_o = rst_pulse_q;
   assign charging_o = charging_q;
   assign fault_o = fault_q;
   assign state_o = state_q;
endmodule : charge_current_register_block

// ==== tb/charge_reg_monitor.sv ====
// checker for charge register block ports
// assumes bound into charge_current_register_block
`timescale 1ns/10ps
module charge_reg_monitor (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire charge_reg_pkg::reg_req_t req_i,
   input wire logic termination_allow_i,
   input wire logic charge_enable_i,
   input wire logic below_refresh_i,
   input wire logic [7:0] rdata_o,
   input wire logic [2:0] fast_charge_sense_threshold_o,
   input wire logic [2:0] termination_sense_threshold_o,
   input wire logic charger_reset_o,
   input wire logic charging_o,
   input wire logic [2:0] fault_o,
   input wire charge_reg_pkg::charge_state_t state_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic wr4;
   logic go;
   assign wr4 = clk_en_i && req_i.wr && req_i.addr == 8'h04;
   assign go = clk_en_i && !charger_reset_o && charge_enable_i;
   sequence s_rst_wr;
      wr4 && req_i.wdata[7];
   endsequence
   sequence s_rst_done;
      charger_reset_o && clk_en_i ##1
      fast_charge_sense_threshold_o == 3'h0 && termination_sense_threshold_o == 3'h1;
   endsequence
   a_reset_pulse: assert property (s_rst_wr |=> s_rst_done)
      else $error("reset write missed pulse or defaults");
   a_bit7_reads: assert property (clk_en_i && req_i.rd && req_i.addr == 8'h04
      |=> rdata_o[7]) else $error("bit seven read as zero");
   a_chrg_field: assert property (wr4 && !req_i.wdata[7] && !charger_reset_o
      |=> fast_charge_sense_threshold_o == $past(req_i.wdata[6:4]))
      else $error("charge field not written");
   a_term_field: assert property (wr4 && !req_i.wdata[7] && !charger_reset_o
      |=> termination_sense_threshold_o == $past(req_i.wdata[2:0]))
      else $error("termination field not written");
   a_id_rev: assert property (clk_en_i && req_i.rd && req_i.addr == 8'h03
      |=> rdata_o[2:0] == charge_reg_pkg::SILICON_REV_FIELD) else $error("bad revision");
   a_recharge: assert property (go && below_refresh_i && state_o == charge_reg_pkg::ST_DONE
      |=> state_o == charge_reg_pkg::ST_CHARGING) else $error("no recharge");
   a_term_allow: assert property (clk_en_i && !termination_allow_i
      && state_o == charge_reg_pkg::ST_CHARGING |=> state_o != charge_reg_pkg::ST_DONE)
      else $error("terminated while not allowed");
   a_fault_stop: assert property (state_o == charge_reg_pkg::ST_FAULT |-> !charging_o)
      else $error("charging in fault");
   a_fault_code: assert property (state_o == charge_reg_pkg::ST_FAULT |-> fault_o == 3'h6)
      else $error("wrong fault code");
endmodule : charge_reg_monitor
bind charge_current_register_block charge_reg_monitor i_mon (.*);

// ==== tb/charge_host_model.sv ====
// host model issuing byte register requests
// assumes tasks are called from the bench top
`timescale 1ns/10ps
module charge_host_model (
   input wire logic ref_clk_i,
   output charge_reg_pkg::reg_req_t req_o
);
   initial req_o = '0;
   task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      req_o = '{wr: w, rd: !w, addr: a, wdata: d & 8'hF7};
      @(negedge ref_clk_i);
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : issue
endmodule : charge_host_model

// ==== tb/charge_current_register_block_tb_top.sv ====
// bench for the charge register block
// assumes the host model drives the request port
`timescale 1ns/10ps
module charge_current_register_block_tb_top;
   logic ref_clk_i, reset_n_i, clk_en_i, termination_allow_i, charge_enable_i;
   logic below_refresh_i, low_current_i, charger_reset_o, charging_o;
   charge_reg_pkg::reg_req_t req_i;
   logic [7:0] rdata_o;
   logic [2:0] fast_charge_sense_threshold_o, termination_sense_threshold_o, fault_o;
   charge_reg_pkg::charge_state_t state_o;
   logic [7:0] id_val;
   int error_cnt = 0;
   int cmp_count = 0;
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   charge_host_model i_host (.ref_clk_i(ref_clk_i), .req_o(req_i));
   charge_current_register_block #(.SAFETY_CYCLES(20)) i_dut (.*);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_host.issue(1'b0, a, 8'h00);
      chk(rdata_o, exp);
   endtask : rd_chk
   task automatic st_chk(input int n, input charge_reg_pkg::charge_state_t e);
      repeat (n) @(negedge ref_clk_i);
      chk({6'h00, state_o}, {6'h00, e});
   endtask : st_chk
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (2000) @(posedge ref_clk_i);
      error_cnt++;
      give_verdict();
   end
   initial begin
      id_val = {charge_reg_pkg::ID_UPPER, charge_reg_pkg::SILICON_REV_FIELD};
      {reset_n_i, termination_allow_i, charge_enable_i, below_refresh_i, low_current_i} = '0;
      clk_en_i = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      rd_chk(8'h04, 8'h89);
      rd_chk(8'h03, id_val);
      $display("test reset values done");
      i_host.issue(1'b1, 8'h04, 8'h5E);
      chk({1'b0, fast_charge_sense_threshold_o, 1'b0, termination_sense_threshold_o}, 8'h56);
      rd_chk(8'h04, 8'hD6);
      i_host.issue(1'b1, 8'h03, 8'hFF);
      rd_chk(8'h03, id_val);
      rd_chk(8'h07, 8'h00);
      $display("test write readback done");
      i_host.issue(1'b1, 8'h04, 8'hB3);
      chk({7'h00, charger_reset_o}, 8'h01);
      rd_chk(8'h04, 8'h89);
      $display("test reset bit done");
      clk_en_i = 1'b0;
      i_host.issue(1'b1, 8'h04, 8'h70);
      clk_en_i = 1'b1;
      chk({5'h00, fast_charge_sense_threshold_o}, 8'h00);
      rd_chk(8'h04, 8'h89);
      $display("test clock enable done");
      charge_enable_i = 1'b1;
      low_current_i = 1'b1;
      st_chk(5, charge_reg_pkg::ST_CHARGING);
      termination_allow_i = 1'b1;
      st_chk(2, charge_reg_pkg::ST_DONE);
      low_current_i = 1'b0;
      below_refresh_i = 1'b1;
      st_chk(2, charge_reg_pkg::ST_CHARGING);
      below_refresh_i = 1'b0;
      st_chk(30, charge_reg_pkg::ST_FAULT);
      chk({5'h00, fault_o}, 8'h06);
      chk({7'h00, charging_o}, 8'h00);
      charge_enable_i = 1'b0;
      st_chk(2, charge_reg_pkg::ST_READY);
      $display("test charge cycle done");
      i_host.issue(1'b1, 8'h04, 8'h25);
      chk({5'h00, termination_sense_threshold_o}, 8'h05);
      reset_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      chk({5'h00, fault_o}, 8'h00);
      rd_chk(8'h04, 8'h89);
      st_chk(1, charge_reg_pkg::ST_READY);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule : charge_current_register_block_tb_top
